//--- dv/sfwp_host.sv
module sfwp_host (
  input  wire logic clk,  // Core clock
  input  wire logic so,   // Data line 1 reply
  output logic      csN,  // Chip select, active low
  output logic      sclk, // Serial clock, idle low
  output logic      io0   // Data line 0
);
  timeunit 1ns;
  timeprecision 100ps;
  initial
  begin
    csN = 1'b1;
    sclk = 1'b0;
    io0 = 1'b0;
  end
  // Moves n core clock periods, to just after an edge.
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Shifts n bits MSB first at 200 ns per bit, then deselects.
  task automatic cmd(input logic [7:0] q[$], input int n);
    int i;
    tick(1);
    csN = 1'b0;
    for (i = 0; i < n; i++)
    begin
      io0 = q[i/8][7-i%8];
      tick(4);
      sclk = 1'b1;
      tick(4);
      sclk = 1'b0;
    end
    tick(2);
    io0 = ~io0; // Released line must not look held.
    tick(2);
    csN = 1'b1;
    tick(8);
  endtask
  // Shifts an opcode, then takes one reply byte from line 1, one bit just before each rise.
  task automatic rd(input logic [7:0] op, output logic [7:0] d);
    int i;
    tick(1);
    csN = 1'b0;
    for (i = 0; i < 16; i++)
    begin
      io0 = op[7-i%8];
      tick(4);
      if (i > 7)
        d[15-i] = so;
      sclk = 1'b1;
      tick(4);
      sclk = 1'b0;
    end
    tick(4);
    csN = 1'b1;
    tick(8);
  endtask
endmodule // sfwp_host

//--- dv/sfwp_props.sv
module sfwp_props (
  input wire logic core_clk,              // Clock
  input wire logic rst,                   // Reset
  input wire logic progReq,               // Program pulse
  input wire logic eraseReq,              // Erase pulse
  input wire logic refusedPulse,          // Refusal pulse
  input wire logic reqSecured,            // One-time target
  input wire logic writeEnableLatch,      // Latch state
  input wire logic deepPowerDown,         // Power-down state
  input wire logic securedMode,           // One-time mode
  input wire logic quadCommandMode,       // Quad mode
  input wire logic hardwareProtectedMode  // Pin protection
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  property p_pulse; progReq |=> !progReq; endproperty
  a_pulse: assert property (p_pulse) else $error("long pulse");
  property p_latch; progReq |-> $past(writeEnableLatch); endproperty
  a_latch: assert property (p_latch) else $error("no latch");
  property p_ref; refusedPulse |-> !progReq ##[0:2] !writeEnableLatch; endproperty
  a_ref: assert property (p_ref) else $error("refusal");
  property p_dpd; deepPowerDown && $past(deepPowerDown) |-> !progReq && !eraseReq; endproperty
  a_dpd: assert property (p_dpd) else $error("power-down");
  property p_secEr; eraseReq |-> !securedMode; endproperty
  a_secEr: assert property (p_secEr) else $error("secured erase");
  property p_secPr; progReq |-> reqSecured == securedMode; endproperty
  a_secPr: assert property (p_secPr) else $error("secured target");
  property p_hpm; hardwareProtectedMode |-> !quadCommandMode; endproperty
  a_hpm: assert property (p_hpm) else $error("pin protect");
  property p_idle; $fell(rst) |-> !writeEnableLatch && !securedMode && !quadCommandMode; endproperty
  a_idle: assert property (p_idle) else $error("not idle");
  c_prog: cover property (progReq && reqSecured);
  c_ref: cover property (refusedPulse);
  c_erase: cover property (eraseReq);
endmodule // sfwp_props

bind sfwp_top sfwp_props chk (.core_clk(core_clk), .rst(rst), .progReq(progReq),
  .eraseReq(eraseReq), .refusedPulse(refusedPulse), .reqSecured(reqSecured),
  .writeEnableLatch(writeEnableLatch), .deepPowerDown(deepPowerDown),
  .securedMode(securedMode), .quadCommandMode(quadCommandMode),
  .hardwareProtectedMode(hardwareProtectedMode));

//--- dv/sfwp_top_tb_top.sv
module sfwp_top_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic wpN = 1'b1;
  logic fLock = 1'b0;
  logic [7:0] rdv;
  wire csN, sclk, hIo0, o0, e0, o1, e1, o2, e2, o3, e3, pr, er, rs, rf;
  wire write_enable_latch, dpd, sec, quad, hardware_protected_mode, cls;
  wire [24:0] ra;
  wire [7:0] rd;
  int bad_count = 0, compares = 0, nP = 0, nR = 0, nE = 0, nC = 0;
  logic [14:0] rows [9] = '{{4'd1, 2'b01, 9'd511}, {4'd1, 2'b00, 9'd510},
    {4'd9, 2'b01, 9'd256}, {4'd9, 2'b00, 9'd255}, {4'd2, 2'b11, 9'd1},
    {4'd2, 2'b10, 9'd2}, {4'd10, 2'b01, 9'd0}, {4'd0, 2'b10, 9'd0}, {4'd15, 2'b11, 9'd511}};
  always #12.5 core_clk = ~core_clk;
  sfwp_host host (.clk(core_clk), .so(e1 ? o1 : ~o1), .csN(csN), .sclk(sclk), .io0(hIo0));
  sfwp_top dut (.core_clk(core_clk), .rst(rst), .chipSelectN(csN), .serialClk(sclk),
    .serialInIo0In(e0 ? o0 : hIo0), .serialInIo0Out(o0), .serialInIo0Oe(e0),
    .serialOutIo1In(e1 ? o1 : 1'b1), .serialOutIo1Out(o1), .serialOutIo1Oe(e1),
    .writeProtectNIo2In(e2 ? o2 : wpN), .writeProtectNIo2Out(o2), .writeProtectNIo2Oe(e2),
    .hwResetNIo3In(e3 ? o3 : 1'b1), .hwResetNIo3Out(o3), .hwResetNIo3Oe(e3),
    .arrayBusy(1'b0), .factoryLockNv(fLock), .customerLockNv(1'b0), .progReq(pr),
    .eraseReq(er), .reqSecured(rs), .reqAddr(ra), .reqData(rd), .refusedPulse(rf),
    .customerLockSet(cls), .writeEnableLatch(write_enable_latch), .deepPowerDown(dpd), .securedMode(sec),
    .quadCommandMode(quad), .hardwareProtectedMode(hardware_protected_mode));
  // Counts the one-cycle request pulses.
  always @(posedge core_clk)
  begin
    nP += (pr === 1'b1);
    nR += (rf === 1'b1);
    nE += (er === 1'b1);
    nC += (cls === 1'b1);
  end
  task automatic close_out;
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (e !== g)
    begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic send(input logic [7:0] q[$]);
    host.cmd(q, q.size() * 8);
  endtask
  // Sets the latch, then programs one byte at the start of a block.
  task automatic prog(input logic [8:0] b, input int r);
    int p0, r0;
    p0 = nP;
    r0 = nR;
    send('{8'h10});
    send('{8'h14, {7'h0, b[8]}, b[7:0], 8'h00, 8'h00, 8'ha5});
    chk("prog", 32'(p0 + 1 - r), 32'(nP));
    chk("refused", 32'(r0 + r), 32'(nR));
    chk("addr", 32'({b, 16'h0000}), 32'(ra));
  endtask
  // Main sequence of scenarios.
  initial
  begin
    repeat (2) @(posedge core_clk);
    #1 rst = 1'b0;
    repeat (4) @(posedge core_clk);
    chk("idle", 32'h0, 32'({write_enable_latch, dpd, sec, quad}));
    host.cmd('{8'h10, 8'h00}, 12);
    chk("partial", 32'h0, 32'(write_enable_latch));
    send('{8'h14, 8'h01, 8'hff, 8'h00, 8'h00, 8'h11});
    chk("nolatch", 32'h0, 32'(nP));
    send('{8'h10});
    send('{8'h15, 8'h00, 8'h00, 8'h00, 8'h00});
    chk("erase", 32'h1, 32'(nE));
    send('{8'h16});
    send('{8'h10});
    chk("pdLatch", 32'h2, 32'({dpd, write_enable_latch}));
    send('{8'h17});
    chk("pdOut", 32'h0, 32'(dpd));
    foreach (rows[k])
    begin
      send('{8'h10});
      send('{8'h13, {2'b00, rows[k][14:11], 2'b00}, {4'h0, rows[k][10], 3'b000}});
      prog(rows[k][8:0], 32'(rows[k][9]));
    end
    send('{8'h10});
    send('{8'h13, 8'h80});
    wpN = 1'b0;
    send('{8'h10});
    send('{8'h13, 8'hbc});
    chk("hpm", 32'h1, 32'(hardware_protected_mode));
    prog(9'd0, 0);
    send('{8'h1f});
    chk("quad", 32'h2, 32'({quad, hardware_protected_mode}));
    rst = 1'b1;
    repeat (2) @(posedge core_clk);
    #1 rst = 1'b0;
    wpN = 1'b1;
    repeat (4) @(posedge core_clk);
    chk("rstQuad", 32'h0, 32'(quad));
    send('{8'h19});
    send('{8'h10});
    send('{8'h14, 8'h00, 8'h00, 8'h00, 8'h10, 8'h5a});
    chk("otp", 32'h0100105a, 32'({rs, ra[15:0], rd}));
    send('{8'h10});
    send('{8'h15, 8'h00, 8'h00, 8'h00, 8'h00});
    chk("otpErase", 32'h1, 32'(nE));
    send('{8'h1a});
    chk("otpExit", 32'h0, 32'(sec));
    // Status reply, customer lock, and the lock bits in the security reply.
    send('{8'h10});
    host.rd(8'h12, rdv);
    chk("status", 32'h02, 32'(rdv));
    send('{8'h1c});
    chk("custSet", 32'h1, 32'(nC));
    send('{8'h10});
    send('{8'h1c});
    chk("custOnce", 32'h1, 32'(nC));
    send('{8'h19});
    send('{8'h10});
    send('{8'h14, 8'h00, 8'h00, 8'h00, 8'h20, 8'h77});
    chk("custLock", 32'h7, 32'(nR));
    fLock = 1'b1;
    host.rd(8'h1b, rdv);
    chk("security", 32'h07, 32'(rdv));
    fLock = 1'b0;
    host.rd(8'h1b, rdv);
    chk("lockHeld", 32'h07, 32'(rdv));
    send('{8'h1a});
    close_out();
  end
  // Cuts a hang short well beyond the expected run length.
  initial
  begin
    repeat (60000) @(posedge core_clk);
    bad_count++;
    close_out();
  end
endmodule // sfwp_top_tb_top

//--- hw/sfwp_region_check.v
`include "sfwp_defines.vh"

// ----------------------------------------------------------------------
// Protection check for one program or erase target
// ----------------------------------------------------------------------
module sfwp_region_check (
  input  wire [24:0] targetAddr,   // Byte address of the target
  input  wire [3:0]  protectLevel, // Protect level bits
  input  wire        topBottom,    // Set protects from block 0 upward
  input  wire        securedMode,  // One-time region mode active
  input  wire        isErase,      // Target belongs to an erase
  input  wire        factoryLock,  // Factory lock of the serial number
  input  wire        customerLock, // Customer lock of the user part
  output wire        allowed       // High when the change may proceed
);

  wire [9:0] block;
  wire [9:0] span;
  wire       topHit;
  wire       bottomHit;
  wire       arrayProt;
  wire       otpProt;
  wire [8:0] otpOffset;

  // Level n covers 2^(n-1) blocks; level 0 gives an empty span.
  assign block     = {1'b0, targetAddr[24:16]};
  assign span      = (protectLevel == 4'h0) ? 10'h000 : (10'h001 << (protectLevel - 4'h1));
  assign topHit    = (block >= (`SFWP_BLOCK_COUNT - span)) && (span != 10'h000);
  assign bottomHit = block < span;

  // Codes ten and above cover every block whatever the side select.
  assign arrayProt = (protectLevel >= `SFWP_LEVEL_ALL) |
                     (topBottom ? bottomHit : topHit);

  // Serial number words follow the factory lock, the rest the customer lock.
  assign otpOffset = targetAddr[8:0];
  assign otpProt   = isErase |
                     ((otpOffset <= `SFWP_OTP_SERIAL_END) ? factoryLock
                                                         : customerLock);

  assign allowed = securedMode ? ~otpProt : ~arrayProt;

endmodule // sfwp_region_check

//--- hw/sfwp_top.v
`include "sfwp_defines.vh"

module sfwp_top #(
  parameter [7:0] SIGNATURE = 8'h5a  // Signature byte, arbitrary value
) (
  input  wire        core_clk,            // System clock, 40 MHz
  input  wire        rst,                 // Synchronous reset, active high
  input  wire        chipSelectN,         // Chip select pin, active low
  input  wire        serialClk,           // Serial clock pin
  input  wire        serialInIo0In,       // Data line 0 input
  output wire        serialInIo0Out,      // Data line 0 output
  output wire        serialInIo0Oe,       // Data line 0 output enable
  input  wire        serialOutIo1In,      // Data line 1 input
  output wire        serialOutIo1Out,     // Data line 1 output
  output wire        serialOutIo1Oe,      // Data line 1 output enable
  input  wire        writeProtectNIo2In,  // Write protect or data line 2
  output wire        writeProtectNIo2Out, // Data line 2 output
  output wire        writeProtectNIo2Oe,  // Data line 2 output enable
  input  wire        hwResetNIo3In,       // Reset pin or data line 3
  output wire        hwResetNIo3Out,      // Data line 3 output
  output wire        hwResetNIo3Oe,       // Data line 3 output enable
  input  wire        arrayBusy,           // Array is programming or erasing
  input  wire        factoryLockNv,       // Stored factory lock
  input  wire        customerLockNv,      // Stored customer lock
  output reg         progReq,             // Program request pulse
  output reg         eraseReq,            // Block erase request pulse
  output reg         reqSecured,          // Request targets the one-time region
  output reg  [24:0] reqAddr,             // Request byte address
  output reg  [7:0]  reqData,             // Program data byte
  output reg         refusedPulse,        // Protected target refused
  output reg         customerLockSet,     // Pulse to store the customer lock
  output wire        writeEnableLatch,    // Write enable latch state
  output wire        deepPowerDown,       // Deep power-down state
  output wire        securedMode,         // One-time region mode state
  output wire        quadCommandMode,     // Quad command mode state
  output wire        hardwareProtectedMode // Pin protection in force
);

  // --------------------------------------------------------------------
  // Machine states
  // --------------------------------------------------------------------
  localparam [3:0] ST_STANDBY = 4'b0001;
  localparam [3:0] ST_CMD     = 4'b0010;
  localparam [3:0] ST_OUT     = 4'b0100;
  localparam [3:0] ST_IGNORE  = 4'b1000;

  // --------------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------------
  reg  [5:0] pinMeta_q;
  reg  [5:0] pinSync_q;
  reg  [1:0] pinDly_q;
  wire [5:0] pinRaw;

  assign pinRaw = {hwResetNIo3In, writeProtectNIo2In, serialOutIo1In, serialInIo0In,
                   serialClk, chipSelectN};

  // Two flops per pin, then a third stage on select and clock for edges.
  // Reset values are the idle pin levels, so no false edge or pin reset follows.
  always @(posedge core_clk)
  begin
    if (rst)
    begin
      pinMeta_q <= 6'h31;
      pinSync_q <= 6'h31;
      pinDly_q  <= 2'h1;
    end
    else
    begin
      pinMeta_q <= pinRaw;
      pinSync_q <= pinMeta_q;
      pinDly_q  <= pinSync_q[1:0];
    end
  end

  wire       csFall  = ~pinSync_q[0] & pinDly_q[0];
  wire       csRise  = pinSync_q[0] & ~pinDly_q[0];
  wire       clkRise = pinSync_q[1] & ~pinDly_q[1];
  wire       clkFall = ~pinSync_q[1] & pinDly_q[1];
  wire [3:0] ioIn    = pinSync_q[5:2];

  // --------------------------------------------------------------------
  // Control and protection state
  // --------------------------------------------------------------------
  reg  [3:0]  state_q;
  reg  [7:0]  shift_q;
  reg  [2:0]  bitCnt_q;
  reg  [2:0]  byteCnt_q;
  reg  [7:0]  cmd_q;
  reg  [31:0] addr_q;
  reg  [7:0]  data_q;
  reg  [7:0]  outShift_q;
  reg  [3:0]  ioOut_q;
  reg         wel_q;
  reg         dpd_q;
  reg         secured_q;
  reg         quadCmd_q;
  reg         rstEn_q;
  reg  [3:0]  level_q;
  reg         topBottom_q;
  reg         srwd_q;
  reg         quadEn_q;
  reg         factLock_q;
  reg         custLock_q;

  // Data lines take the control pins whenever quad transfers are possible.
  wire       pinsAreData = quadCmd_q | quadEn_q;
  wire       hardware_protected_mode         = srwd_q & ~ioIn[2] & ~pinsAreData;
  wire       pinReset    = ~pinsAreData & ~ioIn[3];
  wire [2:0] step        = quadCmd_q ? 3'd4 : 3'd1;
  wire [7:0] shiftNext   = quadCmd_q ? {shift_q[3:0], ioIn} : {shift_q[6:0], ioIn[0]};
  wire [2:0] bitNext     = bitCnt_q + step;
  wire       byteDone    = clkRise & (bitNext == 3'd0);
  wire [7:0] statusByte  = {srwd_q, quadEn_q, level_q, wel_q, arrayBusy};
  wire [7:0] securityByte = {5'h00, secured_q, custLock_q, factLock_q};

  // Commands that deep power-down still lets through.
  wire dpdPass = (shiftNext == `SFWP_OP_RELEASE_PD) |
                 (shiftNext == `SFWP_OP_READ_SIGNATURE) |
                 (shiftNext == `SFWP_OP_RESET_ENABLE) |
                 (shiftNext == `SFWP_OP_RESET);

  // --------------------------------------------------------------------
  // Protection check of the collected target
  // --------------------------------------------------------------------
  wire targetOk;

  sfwp_region_check u_region (
    .targetAddr   (addr_q[24:0]),
    .protectLevel (level_q),
    .topBottom    (topBottom_q),
    .securedMode  (secured_q),
    .isErase      (cmd_q == `SFWP_OP_BLOCK_ERASE),
    .factoryLock  (factLock_q),
    .customerLock (custLock_q),
    .allowed      (targetOk)
  );

  // A command executes only when select rises on a byte boundary.
  wire execNow = (state_q == ST_CMD) & csRise & (bitCnt_q == 3'd0);
  wire lenIs1  = byteCnt_q == `SFWP_LEN_SIMPLE;

  // --------------------------------------------------------------------
  // Serial command machine
  // --------------------------------------------------------------------
  always @(posedge core_clk)
  begin
    progReq         <= 1'b0;
    eraseReq        <= 1'b0;
    refusedPulse    <= 1'b0;
    customerLockSet <= 1'b0;
    if (rst)
    begin
      state_q     <= ST_STANDBY;
      shift_q     <= 8'h00;
      bitCnt_q    <= 3'd0;
      byteCnt_q   <= 3'd0;
      cmd_q       <= 8'h00;
      addr_q      <= 32'h00000000;
      data_q      <= 8'h00;
      outShift_q  <= 8'h00;
      ioOut_q     <= 4'h0;
      wel_q       <= 1'b0;
      dpd_q       <= 1'b0;
      secured_q   <= 1'b0;
      quadCmd_q   <= 1'b0;
      rstEn_q     <= 1'b0;
      level_q     <= `SFWP_RST_LEVEL;
      topBottom_q <= 1'b0;
      srwd_q      <= 1'b0;
      quadEn_q    <= 1'b0;
      reqSecured  <= 1'b0;
      reqAddr     <= 25'h0000000;
      reqData     <= 8'h00;
    end
    else if (pinReset)
    begin
      state_q <= ST_STANDBY;
    end
    else
    begin
      case (state_q)
        ST_STANDBY:
        begin
          if (csFall)
          begin
            state_q   <= ST_CMD;
            bitCnt_q  <= 3'd0;
            byteCnt_q <= 3'd0;
          end
        end
        ST_CMD:
        begin
          if (clkRise)
          begin
            shift_q  <= shiftNext;
            bitCnt_q <= bitNext;
          end
          if (byteDone)
          begin
            if (byteCnt_q != `SFWP_LEN_PROGRAM)
              byteCnt_q <= byteCnt_q + 3'd1;
            if (byteCnt_q == 3'd0)
            begin
              cmd_q <= shiftNext;
              if (dpd_q & ~dpdPass)
                state_q <= ST_IGNORE;
              else if (shiftNext == `SFWP_OP_READ_STATUS)
              begin
                outShift_q <= statusByte;
                state_q    <= ST_OUT;
              end
              else if (shiftNext == `SFWP_OP_READ_SECURITY)
              begin
                outShift_q <= securityByte;
                state_q    <= ST_OUT;
              end
              else if (shiftNext == `SFWP_OP_READ_SIGNATURE)
              begin
                outShift_q <= SIGNATURE;
                dpd_q      <= 1'b0;
                state_q    <= ST_OUT;
              end
            end
            else if (byteCnt_q <= 3'd4)
              addr_q <= {addr_q[23:0], shiftNext};
            else
              data_q <= shiftNext;
          end
          if (csRise)
            state_q <= ST_STANDBY;
          // Everything below acts at the end of a complete command only.
          if (execNow)
          begin
            rstEn_q <= 1'b0;
            case (cmd_q)
              `SFWP_OP_SET_WRITE_LATCH: if (lenIs1) wel_q <= 1'b1;
              `SFWP_OP_CLR_WRITE_LATCH: if (lenIs1) wel_q <= 1'b0;
              `SFWP_OP_WRITE_STATUS:
              begin
                if (wel_q & (byteCnt_q == `SFWP_LEN_STATUS_ONLY))
                begin
                  wel_q    <= 1'b0;
                  quadEn_q <= addr_q[`SFWP_ST_QUAD_EN];
                  if (~hardware_protected_mode)
                  begin
                    level_q <= addr_q[`SFWP_ST_LEVEL_HI:`SFWP_ST_LEVEL_LO];
                    srwd_q  <= addr_q[`SFWP_ST_SRWD];
                  end
                end
                else if (wel_q & (byteCnt_q == `SFWP_LEN_STATUS_CFG))
                begin
                  wel_q       <= 1'b0;
                  quadEn_q    <= addr_q[8 + `SFWP_ST_QUAD_EN];
                  topBottom_q <= addr_q[`SFWP_CFG_TOP_BOTTOM];
                  if (~hardware_protected_mode)
                  begin
                    level_q <= addr_q[8 + `SFWP_ST_LEVEL_HI:8 + `SFWP_ST_LEVEL_LO];
                    srwd_q  <= addr_q[8 + `SFWP_ST_SRWD];
                  end
                end
              end
              `SFWP_OP_PAGE_PROGRAM, `SFWP_OP_BLOCK_ERASE:
              begin
                if (wel_q & (byteCnt_q == ((cmd_q == `SFWP_OP_PAGE_PROGRAM) ?
                    `SFWP_LEN_PROGRAM : `SFWP_LEN_ERASE)))
                begin
                  wel_q      <= 1'b0;
                  reqSecured <= secured_q;
                  reqAddr    <= secured_q ? {16'h0000, addr_q[8:0]} : addr_q[24:0];
                  reqData    <= data_q;
                  if (targetOk)
                  begin
                    progReq  <= (cmd_q == `SFWP_OP_PAGE_PROGRAM);
                    eraseReq <= (cmd_q == `SFWP_OP_BLOCK_ERASE);
                  end
                  else
                    refusedPulse <= 1'b1;
                end
              end
              `SFWP_OP_WRITE_SECURITY:
              begin
                if (wel_q & lenIs1)
                begin
                  wel_q           <= 1'b0;
                  customerLockSet <= ~custLock_q;
                end
              end
              `SFWP_OP_DEEP_POWER_DOWN: if (lenIs1) dpd_q <= 1'b1;
              `SFWP_OP_RELEASE_PD:      if (lenIs1) dpd_q <= 1'b0;
              `SFWP_OP_ENTER_SECURED:   if (lenIs1) secured_q <= 1'b1;
              `SFWP_OP_EXIT_SECURED:    if (lenIs1) secured_q <= 1'b0;
              `SFWP_OP_ENTER_QUAD_CMD:  if (lenIs1) quadCmd_q <= 1'b1;
              `SFWP_OP_EXIT_QUAD_CMD:   if (lenIs1) quadCmd_q <= 1'b0;
              `SFWP_OP_RESET_ENABLE:    if (lenIs1) rstEn_q <= 1'b1;
              `SFWP_OP_RESET:
              begin
                if (lenIs1 & rstEn_q)
                begin
                  wel_q     <= 1'b0;
                  dpd_q     <= 1'b0;
                  secured_q <= 1'b0;
                  quadCmd_q <= 1'b0;
                end
              end
              default: rstEn_q <= 1'b0;
            endcase
          end
        end
        ST_OUT:
        begin
          // The reply byte repeats for as long as the host keeps clocking.
          if (clkFall)
          begin
            ioOut_q    <= quadCmd_q ? outShift_q[7:4] : {2'b00, outShift_q[7], 1'b0};
            outShift_q <= quadCmd_q ? {outShift_q[3:0], outShift_q[7:4]}
                                    : {outShift_q[6:0], outShift_q[7]};
          end
          if (csRise)
            state_q <= ST_STANDBY;
        end
        ST_IGNORE:
        begin
          if (csRise)
            state_q <= ST_STANDBY;
        end
        default: state_q <= ST_STANDBY;
      endcase
    end
  end

  // --------------------------------------------------------------------
  // One-time region locks
  // --------------------------------------------------------------------
  // Locks only ever accumulate; only rst returns them to zero.
  always @(posedge core_clk)
  begin
    if (rst)
    begin
      factLock_q <= 1'b0;
      custLock_q <= 1'b0;
    end
    else
    begin
      factLock_q <= factLock_q | factoryLockNv;
      custLock_q <= custLock_q | customerLockNv | customerLockSet;
    end
  end

  // --------------------------------------------------------------------
  // Pin drive
  // --------------------------------------------------------------------
  // Only the reply phase drives; quad replies use all four lines.
  wire replying = state_q == ST_OUT;

  assign serialInIo0Out      = ioOut_q[0];
  assign serialOutIo1Out     = ioOut_q[1];
  assign writeProtectNIo2Out = ioOut_q[2];
  assign hwResetNIo3Out      = ioOut_q[3];
  assign serialInIo0Oe       = replying & quadCmd_q;
  assign serialOutIo1Oe      = replying;
  assign writeProtectNIo2Oe  = replying & quadCmd_q;
  assign hwResetNIo3Oe       = replying & quadCmd_q;

  assign writeEnableLatch      = wel_q;
  assign deepPowerDown         = dpd_q;
  assign securedMode           = secured_q;
  assign quadCommandMode       = quadCmd_q;
  assign hardwareProtectedMode = hardware_protected_mode;

endmodule // sfwp_top

//--- shared/sfwp_defines.vh
`ifndef SFWP_DEFINES_VH
`define SFWP_DEFINES_VH

// ----------------------------------------------------------------------
// Command opcodes
// ----------------------------------------------------------------------
`define SFWP_OP_SET_WRITE_LATCH   8'h10
`define SFWP_OP_CLR_WRITE_LATCH   8'h11
`define SFWP_OP_READ_STATUS       8'h12
`define SFWP_OP_WRITE_STATUS      8'h13
`define SFWP_OP_PAGE_PROGRAM      8'h14
`define SFWP_OP_BLOCK_ERASE       8'h15
`define SFWP_OP_DEEP_POWER_DOWN   8'h16
`define SFWP_OP_RELEASE_PD        8'h17
`define SFWP_OP_READ_SIGNATURE    8'h18
`define SFWP_OP_ENTER_SECURED     8'h19
`define SFWP_OP_EXIT_SECURED      8'h1a
`define SFWP_OP_READ_SECURITY     8'h1b
`define SFWP_OP_WRITE_SECURITY    8'h1c
`define SFWP_OP_RESET_ENABLE      8'h1d
`define SFWP_OP_RESET             8'h1e
`define SFWP_OP_ENTER_QUAD_CMD    8'h1f
`define SFWP_OP_EXIT_QUAD_CMD     8'h20

// ----------------------------------------------------------------------
// Command lengths in bytes, opcode included
// ----------------------------------------------------------------------
`define SFWP_LEN_SIMPLE           3'd1
`define SFWP_LEN_STATUS_ONLY      3'd2
`define SFWP_LEN_STATUS_CFG       3'd3
`define SFWP_LEN_ERASE            3'd5
`define SFWP_LEN_PROGRAM          3'd6

// ----------------------------------------------------------------------
// Status and configuration byte fields
// ----------------------------------------------------------------------
`define SFWP_ST_BUSY              0
`define SFWP_ST_WEL               1
`define SFWP_ST_LEVEL_LO          2
`define SFWP_ST_LEVEL_HI          5
`define SFWP_ST_QUAD_EN           6
`define SFWP_ST_SRWD              7
`define SFWP_CFG_TOP_BOTTOM       3

// ----------------------------------------------------------------------
// Security byte fields and one-time region map
// ----------------------------------------------------------------------
`define SFWP_SEC_FACTORY_LOCK     0
`define SFWP_SEC_CUSTOMER_LOCK    1
`define SFWP_SEC_SECURED_MODE     2
`define SFWP_OTP_SERIAL_END       9'h00f
`define SFWP_OTP_LAST             9'h1ff

// ----------------------------------------------------------------------
// Array geometry
// ----------------------------------------------------------------------
`define SFWP_BLOCK_COUNT          10'd512
`define SFWP_LEVEL_ALL            4'd10

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define SFWP_RST_LEVEL            4'h0

`endif
